// *** reset_pin_state_and_shared_pins_test.sv ***
// Testbench for the pin reset state and shared pin block.
// Assumes board model for pin levels; inputs change on falling edges.
`timescale 1ns/1ps

module reset_pin_state_and_shared_pins_test;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	logic                     nmi = 1'b0;
	logic                     en_n = 1'b1;
	logic                     top = 1'b0;
	logic [7:0]               p0 = 8'ha5;
	logic [5:0]               cbo = 6'h00;
	logic                     cbd = 1'b0;
	rpsp_pkg::rpsp_sfr_req_t  req = '0;
	rpsp_pkg::rpsp_pin_in_t   pins;
	rpsp_pkg::rpsp_pin_ctrl_t ctl;
	rpsp_pkg::rpsp_pin_ctrl_t exp_ctl;
	logic [5:0]               cbi;
	logic [7:0]               rdata;
	logic                     rvalid;
	logic                     nreq;
	logic [15:0]              nvec;
	int                       err_total = 0;
	int                       total_checks = 0;
	int                       cycles = 0;
	int                       pulses;

	always #12.5 clk = ~clk;

	rpsp_board_model rpsp_board_model_inst (.nmi_i(nmi), .en_n_i(en_n), .p0_i(p0), .top_i(top),
		.ctrl_i(ctl), .pins_o(pins));
	rpsp_pin_ctrl rpsp_pin_ctrl_inst (.core_clk_i(clk), .reset_i(rst), .pins_i(pins),
		.check_bit_out_i(cbo), .check_bit_drive_i(cbd), .check_bit_in_o(cbi), .sfr_req_i(req),
		.sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .nmi_req_o(nreq), .nmi_vector_o(nvec),
		.pin_ctrl_o(ctl));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			print_verdict;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(ctl, rpsp_pkg::PINS_IN_RESET);
		exp_ctl = rpsp_pkg::PINS_IN_RESET;
		exp_ctl.bus_oe = 1'b1;
		exp_ctl.hso_oe = 4'hf;
		exp_ctl.hso_pd = 4'h0;
		exp_ctl.txd_oe = 1'b1;
		exp_ctl.pulse_width_output_zero_oe = 1'b1;
		exp_ctl.bus_pu = 1'b0;
		exp_ctl.txd_pu = 1'b0;
		exp_ctl.pulse_width_output_zero_pd = 1'b0;
		rst = 1'b0;
		cyc(1);
		chk({ctl.bus_oe, ctl.hso_val, ctl.hso_oe, ctl.hso_pd}, {exp_ctl.bus_oe, 12'h0f0});
		chk({ctl.p1_pu, ctl.p0_oe, ctl.cb_top_oe}, {16'hff00, 1'b0});
		chk({ctl.txd, ctl.txd_oe, ctl.pulse_width_output_zero, ctl.pulse_width_output_zero_oe}, 4'hd);
		chk(ctl, exp_ctl);
		chk({cbi, nreq, rvalid}, 8'h00);
		$display("reset test done");
	endtask

	task automatic t_read;
		cyc(3);
		req = '{rd: 1'b1, window: 4'h0, addr: 8'h0e};
		cyc(1);
		chk({rvalid, rdata}, 9'h1a5);
		req.addr = 8'h0f;
		cyc(1);
		chk({rvalid, rdata}, 9'h100);
		req = '{rd: 1'b1, window: 4'h1, addr: 8'h0e};
		cyc(1);
		chk({rvalid, rdata}, 9'h100);
		req = '0;
		cyc(1);
		chk({rvalid, rdata}, 9'h000);
		$display("read test done");
	endtask

	task automatic t_nmi;
		pulses = 0;
		nmi = 1'b1;
		repeat (8)
		begin
			cyc(1);
			pulses += (nreq === 1'b1);
		end
		nmi = 1'b0;
		chk(pulses, 1);
		chk(nvec, 16'h203e);
		$display("interrupt test done");
	endtask

	task automatic t_check_bits;
		en_n = 1'b0;
		cbd = 1'b1;
		cbo = 6'h2a;
		cyc(8);
		chk({ctl.p0_oe, ctl.cb_top_oe, ctl.p0_out & 8'h4f, ctl.cb_top_out}, {8'h4f, 1'b1, 8'h06, 1'b1});
		chk(cbi, 6'h2a);
		cbd = 1'b0;
		p0 = 8'hc9;
		top = 1'b1;
		cyc(8);
		chk({ctl.p0_oe, ctl.cb_top_oe, cbi}, {9'h000, 6'h35});
		en_n = 1'b1;
		cbd = 1'b1;
		cyc(8);
		chk({ctl.p0_oe, ctl.cb_top_oe, cbi}, 15'h0000);
		$display("check bit test done");
	endtask

	task automatic t_mid_reset;
		en_n = 1'b0;
		cbd = 1'b1;
		cyc(4);
		chk({ctl.p0_oe, ctl.cb_top_oe}, 9'h09f);
		rst = 1'b1;
		cyc(1);
		chk(ctl, rpsp_pkg::PINS_IN_RESET);
		chk({cbi, nreq, rvalid}, 8'h00);
		rst = 1'b0;
		cyc(2);
		chk({ctl.p0_oe, ctl.cb_top_oe}, 9'h000);
		cyc(1);
		chk({ctl.p0_oe, ctl.cb_top_oe, ctl.bus_oe}, 10'h13f);
		en_n = 1'b1;
		cbd = 1'b0;
		cyc(4);
		$display("mid reset test done");
	endtask

	initial
	begin
		cyc(2);
		t_reset();
		t_read();
		t_nmi();
		t_check_bits();
		t_mid_reset();
		print_verdict();
	end
endmodule // reset_pin_state_and_shared_pins_test

// *** rpsp_board_model.sv ***
// Board model: levels that the board puts on the block's pins.
// Assumes pin controls from the block; a driven check pin shows the block's value.
`timescale 1ns/1ps

module rpsp_board_model
(
	// Board levels
	input  wire logic                     nmi_i,
	input  wire logic                     en_n_i,
	input  wire logic [7:0]               p0_i,
	input  wire logic                     top_i,
	// Block drive controls
	input  wire rpsp_pkg::rpsp_pin_ctrl_t ctrl_i,
	// Resolved pin levels
	output rpsp_pkg::rpsp_pin_in_t        pins_o
);
	assign pins_o = '{nmi: nmi_i, cb_en_n: en_n_i,
		cb_top: ctrl_i.cb_top_oe ? ctrl_i.cb_top_out : top_i,
		p0: (ctrl_i.p0_oe & ctrl_i.p0_out) | (~ctrl_i.p0_oe & p0_i)};
endmodule // rpsp_board_model

// *** rpsp_note_end.sv ***
`timescale 1ns/1ps

// *** rpsp_pin_ctrl.sv ***
// Reset pin state, shared port 0 check bit pins and nonmaskable interrupt input.
// Assumes the error correction engine and register file share core_clk_i; pins are asynchronous.
// Behaviour
// [RULE1] Rising nonmaskable input vectors through 203Eh.
// [RULE2] Source holds nonmaskable input high one state.
// [RULE3] Input port read at 0Eh, window zero.
// [RULE4] Enabled check bits use shared port pins.
// [RULE5] Check pins driven only while enable low.
// [RULE6] High speed outputs pulled down, then driven low.
// [RULE7] Port one pins stay weakly pulled up.
// [RULE8] Check bit port pins inputs during reset.
// [RULE9] Non check port zero pins always inputs.
// [RULE10] Transmit high, pulse output low, bus driven.
`timescale 1ns/1ps

module rpsp_pin_ctrl
(
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	// Pin levels
	input  wire rpsp_pkg::rpsp_pin_in_t   pins_i,
	// Check bit engine
	input  wire logic [5:0]               check_bit_out_i,
	input  wire logic                     check_bit_drive_i,
	output logic      [5:0]               check_bit_in_o,
	// Register read
	input  wire rpsp_pkg::rpsp_sfr_req_t  sfr_req_i,
	output logic      [7:0]               sfr_rdata_o,
	output logic                          sfr_rvalid_o,
	// Interrupt controller
	output logic                          nmi_req_o,
	output logic      [15:0]              nmi_vector_o,
	// Pin drive controls
	output rpsp_pkg::rpsp_pin_ctrl_t      pin_ctrl_o
);

	////////////////////////////////////////////////////////////////////////////
	// Check bit mapping onto port 0

	function automatic logic [4:0] gather_low(input logic [7:0] p0);
		gather_low = {p0[rpsp_pkg::P0_POS_CB4], p0[rpsp_pkg::P0_POS_CB3], p0[rpsp_pkg::P0_POS_CB2],
			p0[rpsp_pkg::P0_POS_CB1], p0[rpsp_pkg::P0_POS_CB0]};
	endfunction

	function automatic logic [7:0] scatter_low(input logic [4:0] cb);
		logic [7:0] p;
		p = rpsp_pkg::BYTE_ZERO;
		p[rpsp_pkg::P0_POS_CB0] = cb[0];
		p[rpsp_pkg::P0_POS_CB1] = cb[1];
		p[rpsp_pkg::P0_POS_CB2] = cb[2];
		p[rpsp_pkg::P0_POS_CB3] = cb[3];
		p[rpsp_pkg::P0_POS_CB4] = cb[4];
		scatter_low = p;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	rpsp_pkg::rpsp_pin_in_t   sync1_q, sync1_d;
	rpsp_pkg::rpsp_pin_in_t   sync2_q, sync2_d;
	logic                     nmi_prev_q, nmi_prev_d;
	logic                     nmi_req_q, nmi_req_d;
	logic [5:0]               cb_in_q, cb_in_d;
	logic [7:0]               rdata_q, rdata_d;
	logic                     rvalid_q, rvalid_d;
	logic                     up_q, up_d;
	rpsp_pkg::rpsp_pin_ctrl_t pins_q, pins_d;
	logic                     cb_enabled;
	logic                     p0_read;

	// Synchronisers idle with the enable pin released, so reset never shows a false enable
	localparam rpsp_pkg::rpsp_pin_in_t SYNC_IDLE = '{nmi: 1'b0, cb_en_n: 1'b1, cb_top: 1'b0,
		p0: rpsp_pkg::BYTE_ZERO};

	always_comb
	begin
		sync1_d    = pins_i;
		sync2_d    = sync1_q;
		nmi_prev_d = sync2_q.nmi;
		up_d       = 1'b1;
		cb_enabled = ~sync2_q.cb_en_n;
		// [RULE1] Rising edge detect
		nmi_req_d  = sync2_q.nmi & ~nmi_prev_q;
		// [RULE4] Check bits from pins
		cb_in_d    = cb_enabled ? {sync2_q.cb_top, gather_low(sync2_q.p0)} : rpsp_pkg::CB_ZERO;
		// [RULE3] Port zero read
		p0_read    = sfr_req_i.rd && (sfr_req_i.window == rpsp_pkg::SFR_WINDOW_ZERO)
			&& (sfr_req_i.addr == rpsp_pkg::PORT0_SFR_ADDR);
		rdata_d    = p0_read ? sync2_q.p0 : rpsp_pkg::BYTE_ZERO;
		rvalid_d   = sfr_req_i.rd;
		// Pin state once reset has been released
		pins_d            = rpsp_pkg::PINS_IN_RESET;
		// [RULE10] Bus driven, pull up off
		pins_d.bus_oe     = 1'b1;
		pins_d.bus_pu     = 1'b0;
		// [RULE6] High speed driven low
		pins_d.hso_val    = rpsp_pkg::HSO_LOW;
		pins_d.hso_oe     = rpsp_pkg::HSO_ALL_PINS;
		pins_d.hso_pd     = rpsp_pkg::HSO_LOW;
		// [RULE7] Weak pull up kept
		pins_d.p1_pu      = rpsp_pkg::P1_ALL_PINS;
		// [RULE10] Transmit idle, pulse low
		pins_d.txd        = 1'b1;
		pins_d.txd_oe     = 1'b1;
		pins_d.txd_pu     = 1'b0;
		pins_d.pulse_width_output_zero       = 1'b0;
		pins_d.pulse_width_output_zero_oe    = 1'b1;
		pins_d.pulse_width_output_zero_pd    = 1'b0;
		// [RULE5] Drive only when enabled
		pins_d.p0_out     = scatter_low(check_bit_out_i[4:0]);
		// [RULE9] Only masked pins driven
		pins_d.p0_oe      = (cb_enabled && check_bit_drive_i) ? rpsp_pkg::P0_CB_MASK : rpsp_pkg::BYTE_ZERO;
		pins_d.cb_top_out = check_bit_out_i[5];
		pins_d.cb_top_oe  = cb_enabled && check_bit_drive_i;
	end

	// [RULE8] Reset value leaves pins inputs
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sync1_q    <= SYNC_IDLE;
			sync2_q    <= SYNC_IDLE;
			nmi_prev_q <= 1'b0;
			nmi_req_q  <= 1'b0;
			cb_in_q    <= rpsp_pkg::CB_ZERO;
			rdata_q    <= rpsp_pkg::BYTE_ZERO;
			rvalid_q   <= 1'b0;
			up_q       <= 1'b0;
			pins_q     <= rpsp_pkg::PINS_IN_RESET;
		end
		else
		begin
			sync1_q    <= sync1_d;
			sync2_q    <= sync2_d;
			nmi_prev_q <= nmi_prev_d;
			nmi_req_q  <= nmi_req_d;
			cb_in_q    <= cb_in_d;
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
			up_q       <= up_d;
			pins_q     <= pins_d;
		end
	end

	assign check_bit_in_o = cb_in_q;
	assign sfr_rdata_o    = rdata_q;
	assign sfr_rvalid_o   = rvalid_q;
	assign nmi_req_o      = nmi_req_q;
	assign nmi_vector_o   = rpsp_pkg::NMI_VECTOR;
	assign pin_ctrl_o     = pins_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb_chk @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	AST_NMI_EDGE: assert property (sync2_q.nmi && !nmi_prev_q |=> nmi_req_o && nmi_vector_o == 16'h203e) // [RULE1]
		else $error("nonmaskable edge not requested");

	AST_NMI_ONLY_EDGE: assert property (nmi_req_o |-> $past(sync2_q.nmi) && !$past(nmi_prev_q)) // [RULE1]
		else $error("nonmaskable request without edge");

	AST_PORT0_READ: assert property (sfr_req_i.rd && sfr_req_i.window == 4'h0 && sfr_req_i.addr == 8'h0e // [RULE3]
		|=> sfr_rvalid_o && sfr_rdata_o == $past(sync2_q.p0))
		else $error("port zero read wrong");

	AST_CB_GATHER: assert property (!sync2_q.cb_en_n ##1 1 |-> check_bit_in_o[5] == $past(sync2_q.cb_top) // [RULE4]
		&& check_bit_in_o[0] == $past(sync2_q.p0[6]) && check_bit_in_o[2] == $past(sync2_q.p0[0]))
		else $error("check bits not taken from shared pins");

	AST_CB_DRIVE: assert property (pin_ctrl_o.p0_oe != 8'h00 || pin_ctrl_o.cb_top_oe // [RULE5]
		|-> up_q && !$past(sync2_q.cb_en_n) && $past(check_bit_drive_i))
		else $error("check pins driven while disabled");

	AST_HSO_LOW: assert property (up_q |-> pin_ctrl_o.hso_oe == 4'hf && pin_ctrl_o.hso_val == 4'h0 // [RULE6]
		&& pin_ctrl_o.hso_pd == 4'h0)
		else $error("high speed outputs not driven low");

	AST_P1_PULLUP: assert property (pin_ctrl_o.p1_pu == 8'hff) // [RULE7]
		else $error("port one pull up lost");

	AST_P0_INPUT: assert property ((pin_ctrl_o.p0_oe & 8'hb0) == 8'h00) // [RULE9]
		else $error("input only port zero pin driven");

	AST_OUT_IDLE: assert property (up_q |-> pin_ctrl_o.txd && pin_ctrl_o.txd_oe && !pin_ctrl_o.pulse_width_output_zero // [RULE10]
		&& pin_ctrl_o.pulse_width_output_zero_oe && pin_ctrl_o.bus_oe)
		else $error("idle outputs wrong after reset");

	AST_NMI_SINGLE: assert property (nmi_req_o |=> !nmi_req_o) // [RULE1]
		else $error("nonmaskable request longer than one cycle");

	AST_READ_VALID: assert property (sfr_req_i.rd |=> sfr_rvalid_o) // [RULE3]
		else $error("read not answered");

	AST_READ_IDLE: assert property (!sfr_req_i.rd |=> !sfr_rvalid_o) // [RULE3]
		else $error("read answer without request");

	AST_READ_OTHER: assert property (sfr_req_i.rd && (sfr_req_i.window != 4'h0 || sfr_req_i.addr != 8'h0e) // [RULE3]
		|=> sfr_rdata_o == 8'h00)
		else $error("unmapped read returned data");

	AST_CB_QUIET: assert property (sync2_q.cb_en_n |=> check_bit_in_o == 6'h00) // [RULE4]
		else $error("check bits taken while disabled");

	AST_CB_SCATTER: assert property (pin_ctrl_o.cb_top_oe |-> pin_ctrl_o.cb_top_out == $past(check_bit_out_i[5]) // [RULE4]
		&& pin_ctrl_o.p0_out[3] == $past(check_bit_out_i[4]) && pin_ctrl_o.p0_out[6] == $past(check_bit_out_i[0])
		&& pin_ctrl_o.p0_out[1] == $past(check_bit_out_i[3]))
		else $error("check bits on wrong pins");

	AST_CB_OE_PAIR: assert property (pin_ctrl_o.p0_oe == (pin_ctrl_o.cb_top_oe ? 8'h4f : 8'h00)) // [RULE5]
		else $error("check pin enables disagree");

	AST_PULLS_RELEASED: assert property (up_q |-> !pin_ctrl_o.bus_pu && !pin_ctrl_o.txd_pu // [RULE10]
		&& !pin_ctrl_o.pulse_width_output_zero_pd)
		else $error("reset pulls kept on driven outputs");

endmodule // rpsp_pin_ctrl

// *** rpsp_pkg.sv ***
// Package for the reset pin state and shared pin block.
// Assumes one core clock and an active high asynchronous reset.
package rpsp_pkg;

	// Interrupt vector and register location
	localparam logic [15:0] NMI_VECTOR      = 16'h203e;
	localparam logic [3:0]  SFR_WINDOW_ZERO = 4'h0;
	localparam logic [7:0]  PORT0_SFR_ADDR  = 8'h0e;

	// Port 0 bit that carries each low check bit
	localparam int P0_POS_CB0 = 6;
	localparam int P0_POS_CB1 = 2;
	localparam int P0_POS_CB2 = 0;
	localparam int P0_POS_CB3 = 1;
	localparam int P0_POS_CB4 = 3;

	// Port 0 bits that have a check bit role, then port 1, high speed and zero constants
	localparam logic [7:0] P0_CB_MASK   = 8'h4f;
	localparam logic [7:0] P1_ALL_PINS  = 8'hff;
	localparam logic [3:0] HSO_ALL_PINS = 4'hf;
	localparam logic [3:0] HSO_LOW      = 4'h0;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [5:0] CB_ZERO      = 6'h00;

	// Pin levels seen from outside
	typedef struct packed {
		logic       nmi;
		logic       cb_en_n;
		logic       cb_top;
		logic [7:0] p0;
	} rpsp_pin_in_t;

	// Register read request
	typedef struct packed {
		logic       rd;
		logic [3:0] window;
		logic [7:0] addr;
	} rpsp_sfr_req_t;

	// Drive, enable and pull controls of every pin handled here
	typedef struct packed {
		logic       bus_oe;
		logic       bus_pu;
		logic [3:0] hso_val;
		logic [3:0] hso_oe;
		logic [3:0] hso_pd;
		logic [7:0] p1_pu;
		logic       txd;
		logic       txd_oe;
		logic       txd_pu;
		logic       pulse_width_output_zero;
		logic       pulse_width_output_zero_oe;
		logic       pulse_width_output_zero_pd;
		logic       nmi_pd;
		logic [7:0] p0_out;
		logic [7:0] p0_oe;
		logic       cb_top_out;
		logic       cb_top_oe;
	} rpsp_pin_ctrl_t;

	// Pin state while reset is held
	localparam rpsp_pin_ctrl_t PINS_IN_RESET = '{
		bus_oe: 1'b0, bus_pu: 1'b1,
		hso_val: HSO_LOW, hso_oe: HSO_LOW, hso_pd: HSO_ALL_PINS,
		p1_pu: P1_ALL_PINS,
		txd: 1'b1, txd_oe: 1'b0, txd_pu: 1'b1,
		pulse_width_output_zero: 1'b0, pulse_width_output_zero_oe: 1'b0, pulse_width_output_zero_pd: 1'b1,
		nmi_pd: 1'b1,
		p0_out: BYTE_ZERO, p0_oe: BYTE_ZERO,
		cb_top_out: 1'b0, cb_top_oe: 1'b0
	};

endpackage
